// ---- rtl/ttt_tracker.sv ----
// Target transfer tracker: outstanding table, transfer sequencing, completions
`timescale 1ns/10ps
`include "ttt_defines.svh"

// Summary of operation
// (RULE_01) Normal read request sends a DATA READY message to the initiator.
// (RULE_02) Initiator answers DATA READY with DATA REPLY messages authorising data.
// (RULE_03) Each DATA REPLY is checked against the table entry chosen by its tag.
// (RULE_04) A valid reply starts read data exactly as the reply describes.
// (RULE_05) Last byte of normal read data starts read completion for that channel.
// (RULE_06) Read done: find entry by channel; several channels means drop only that one.
// (RULE_07) Read done on sole channel: report tag and initiator identity, clear entry.
// (RULE_08) Completion result is success or failed from final transfer status.
// (RULE_09) Fast read sends data at once, with no READY or REPLY exchange.
// (RULE_10) Last byte of a fast read signals fast read completion.
// (RULE_11) Write request sends a DATA REQUEST message to the initiator.
// (RULE_12) Initiator answers DATA REQUEST by sending the write data.
// (RULE_13) Last byte of received write data starts write completion.
// (RULE_14) Write done: find entry by channel; several channels means drop only that one.
// (RULE_15) Write done on sole channel: report tag, identity, result, clear entry.
// (RULE_16) A QUIESCE message asks the protocol layer to abort related processes.
// (RULE_17) After abort, a RESPONSE message carries the abort result code.
// (RULE_18) Flagged outgoing messages get bytes 4 to 7 replaced by the return path.
// (RULE_19) A lookup turns a received return path into a node identity.
// (RULE_20) Read or write request creates an entry: tag, path, channels, transfer id.
// (RULE_21) Result codes: 00h success, FEh failed, FFh invalid parameter.
// (RULE_22) Unmatched completion or reply leaves the table alone and flags an error.
// (RULE_23) Table lookup and update happen in one clock, one event per cycle.
module ttt_tracker
  import ttt_pkg::*;
#(
  parameter int NUM_ENT = 4,
  parameter int MAX_CH = 4,
  parameter int MAP_SLOTS = 8
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire ttt_kind_t req_kind,
  input wire logic [`TTT_TAG_W-1:0] req_tag,
  input wire logic [`TTT_UID_W-1:0] req_uid,
  input wire logic [`TTT_CH_W-1:0] req_channel,
  input wire logic [`TTT_XID_W-1:0] req_xfer_id,
  input wire logic [`TTT_CNT_W-1:0] req_count,
  output logic req_invalid,
  output logic ctl_valid,
  input wire logic ctl_ready,
  output ttt_msg_t ctl_type,
  output logic [`TTT_TAG_W-1:0] ctl_tag,
  output logic [`TTT_RPID_W-1:0] ctl_rpid,
  output logic [`TTT_CH_W-1:0] ctl_channel,
  output logic [`TTT_XID_W-1:0] ctl_xfer_id,
  output logic [`TTT_CNT_W-1:0] ctl_count,
  output logic [`TTT_CODE_W-1:0] ctl_code,
  input wire logic reply_valid,
  output logic reply_ready,
  input wire logic [`TTT_TAG_W-1:0] reply_tag,
  input wire logic [`TTT_RPID_W-1:0] reply_rpid,
  input wire logic [`TTT_XID_W-1:0] reply_xfer_id,
  input wire logic [`TTT_CH_W-1:0] reply_channel,
  input wire logic [`TTT_CNT_W-1:0] reply_offset,
  input wire logic [`TTT_CNT_W-1:0] reply_count,
  output logic send_valid,
  output logic send_fast,
  output logic [`TTT_TAG_W-1:0] send_tag,
  output logic [`TTT_CH_W-1:0] send_channel,
  output logic [`TTT_CNT_W-1:0] send_offset,
  output logic [`TTT_CNT_W-1:0] send_count,
  input wire logic done_valid,
  input wire logic done_write,
  input wire logic [`TTT_CH_W-1:0] done_channel,
  input wire logic done_failed,
  input wire logic fast_last,
  output logic fast_cmpl_valid,
  output logic [`TTT_TAG_W-1:0] fast_cmpl_tag,
  output logic cmpl_valid,
  output logic cmpl_write,
  output logic [`TTT_TAG_W-1:0] cmpl_tag,
  output logic [`TTT_UID_W-1:0] cmpl_uid,
  output logic [`TTT_CODE_W-1:0] cmpl_code,
  output logic val_err,
  input wire logic quiesce_valid,
  output logic quiesce_ready,
  input wire logic [`TTT_RPID_W-1:0] quiesce_rpid,
  output logic abort_req,
  input wire logic abort_ack,
  input wire logic [`TTT_CODE_W-1:0] abort_code,
  input wire logic uidq_valid,
  input wire logic [`TTT_RPID_W-1:0] uidq_rpid,
  output logic uidq_done,
  output logic uidq_hit,
  output logic [`TTT_UID_W-1:0] uidq_uid,
  input wire logic map_wr,
  input wire logic [$clog2(MAP_SLOTS)-1:0] map_slot,
  input wire logic [`TTT_RPID_W-1:0] map_rpid,
  input wire logic [`TTT_UID_W-1:0] map_uid,
  input wire logic tx_valid,
  input wire logic tx_first,
  input wire logic [7:0] tx_byte,
  input wire logic path_substitute_flag,
  input wire logic [`TTT_UID_W-1:0] tx_uid,
  output logic txo_valid,
  output logic [7:0] txo_byte
);
  localparam int EW = $clog2(NUM_ENT);
  localparam int CW = $clog2(MAX_CH);

  // Outstanding transfer table
  logic [NUM_ENT-1:0] ent_valid;
  logic [NUM_ENT-1:0] ent_write;
  logic [NUM_ENT-1:0] ent_fail;
  logic [`TTT_TAG_W-1:0] ent_tag [NUM_ENT];
  logic [`TTT_RPID_W-1:0] ent_rpid [NUM_ENT];
  logic [`TTT_XID_W-1:0] ent_xid [NUM_ENT];
  logic [MAX_CH-1:0] ch_valid [NUM_ENT];
  logic [`TTT_CH_W-1:0] ch_val [NUM_ENT][MAX_CH];

  logic fast_busy;
  ttt_qstate_t q_state;
  logic [`TTT_RPID_W-1:0] q_rpid;
  logic [`TTT_CODE_W-1:0] q_code;

  function automatic logic [EW-1:0] first_ent(input logic [NUM_ENT-1:0] v);
    logic [EW-1:0] r;
    r = '0;
    for (int i = NUM_ENT - 1; i >= 0; i--)
      if (v[i]) r = EW'(i);
    return r;
  endfunction : first_ent

  function automatic logic [CW-1:0] first_ch(input logic [MAX_CH-1:0] v);
    logic [CW-1:0] r;
    r = '0;
    for (int i = MAX_CH - 1; i >= 0; i--)
      if (v[i]) r = CW'(i);
    return r;
  endfunction : first_ch

  // Match vectors
  wire [NUM_ENT-1:0] tag_hit_vec;
  wire [NUM_ENT-1:0] dn_hit_vec;
  wire [MAX_CH-1:0] dn_slot_hit [NUM_ENT];
  wire [MAX_CH-1:0] rep_ch_hit;
  wire [EW-1:0] rep_idx = first_ent(tag_hit_vec);

  genvar ge, gc;
  generate
    for (ge = 0; ge < NUM_ENT; ge++)
    begin : g_ent
      assign tag_hit_vec[ge] = ent_valid[ge] && ent_tag[ge] == reply_tag; // RULE_03
      for (gc = 0; gc < MAX_CH; gc++)
      begin : g_ch
        assign dn_slot_hit[ge][gc] = ent_valid[ge] && ent_write[ge] == done_write &&
                                     ch_valid[ge][gc] && ch_val[ge][gc] == done_channel;
      end
      assign dn_hit_vec[ge] = |dn_slot_hit[ge];
    end
    for (gc = 0; gc < MAX_CH; gc++)
    begin : g_rep
      assign rep_ch_hit[gc] = ch_valid[rep_idx][gc] && ch_val[rep_idx][gc] == reply_channel;
    end
  endgenerate

  // Reply validation
  wire rep_hit = |tag_hit_vec;
  wire rep_ok = rep_hit && !ent_write[rep_idx] && ent_rpid[rep_idx] == reply_rpid &&
                ent_xid[rep_idx] == reply_xfer_id; // RULE_03
  wire rep_has_ch = |rep_ch_hit;
  wire rep_room = rep_has_ch || !(&ch_valid[rep_idx]);
  wire [CW-1:0] rep_slot = rep_has_ch ? first_ch(rep_ch_hit) : first_ch(~ch_valid[rep_idx]);
  wire reply_fire = reply_valid && reply_ready;
  wire rep_accept = reply_fire && rep_ok && rep_room;

  // Channel completion lookup
  wire dn_hit = |dn_hit_vec;
  wire [EW-1:0] dn_idx = first_ent(dn_hit_vec); // RULE_06 RULE_14
  wire [CW-1:0] dn_slot = first_ch(dn_slot_hit[dn_idx]);
  wire [MAX_CH-1:0] dn_chs = ch_valid[dn_idx];
  wire dn_last = (dn_chs & (dn_chs - MAX_CH'(1))) == '0;
  wire dn_fail = ent_fail[dn_idx] | done_failed;
  wire dn_apply = done_valid && dn_hit;

  // Request acceptance; completions first, then replies, then new work
  wire [EW-1:0] free_idx = first_ent(~ent_valid);
  wire have_free = |(~ent_valid);
  wire [`TTT_RPID_W-1:0] req_rpid;
  wire req_mapped;
  wire is_fast = req_kind == KIND_FAST;
  wire q_load = q_state == Q_RESP && !ctl_valid;
  assign reply_ready = !done_valid; // RULE_23
  assign req_ready = !done_valid && !reply_valid &&
                     (is_fast ? !fast_busy : (have_free && !ctl_valid && q_state != Q_RESP));
  wire req_fire = req_valid && req_ready;
  wire new_entry = req_fire && !is_fast && req_mapped;
  wire fast_fire = req_fire && is_fast;
  wire [`TTT_UID_W-1:0] dn_uid;
  wire dn_uid_hit;
  wire [`TTT_RPID_W-1:0] sub_rpid;
  wire [`TTT_UID_W-1:0] q_uid;
  wire q_uid_hit;

  assign quiesce_ready = q_state == Q_IDLE;
  assign abort_req = q_state == Q_ABORT; // RULE_16

  ttt_path_map #(
    .SLOTS(MAP_SLOTS)
  ) u_map (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(map_wr),
    .wr_slot(map_slot),
    .wr_rpid(map_rpid),
    .wr_uid(map_uid),
    .a_rpid(ent_rpid[dn_idx]),
    .a_uid(dn_uid),
    .a_hit(dn_uid_hit),
    .b_rpid(uidq_rpid),
    .b_uid(q_uid),
    .b_hit(q_uid_hit),
    .c_uid(req_uid),
    .c_rpid(req_rpid),
    .c_hit(req_mapped),
    .d_uid(tx_uid),
    .d_rpid(sub_rpid)
  );

  ttt_path_subst u_subst (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_first(tx_first),
    .in_byte(tx_byte),
    .path_substitute_flag(path_substitute_flag),
    .sub_rpid(sub_rpid),
    .out_valid(txo_valid),
    .out_byte(txo_byte)
  );

  // Table updates, one event per cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ent_valid <= '0;
      for (int i = 0; i < NUM_ENT; i++)
        ch_valid[i] <= '0;
    end
    else if (dn_apply)
    begin
      ch_valid[dn_idx][dn_slot] <= 1'b0; // RULE_06 RULE_14
      ent_fail[dn_idx] <= dn_fail;
      if (dn_last)
        ent_valid[dn_idx] <= 1'b0; // RULE_07 RULE_15
    end
    else if (rep_accept)
    begin
      ch_valid[rep_idx][rep_slot] <= 1'b1;
      ch_val[rep_idx][rep_slot] <= reply_channel;
    end
    else if (new_entry)
    begin
      ent_valid[free_idx] <= 1'b1; // RULE_20
      ent_write[free_idx] <= req_kind == KIND_WRITE;
      ent_fail[free_idx] <= 1'b0;
      ent_tag[free_idx] <= req_tag;
      ent_rpid[free_idx] <= req_rpid;
      ent_xid[free_idx] <= req_xfer_id;
      ch_valid[free_idx] <= {{(MAX_CH - 1){1'b0}}, req_kind == KIND_WRITE};
      ch_val[free_idx][0] <= req_channel;
    end
  end

  // Completion reports and error flags
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cmpl_valid <= 1'b0;
      cmpl_write <= 1'b0;
      cmpl_tag <= '0;
      cmpl_uid <= '0;
      cmpl_code <= `TTT_RC_SUCCESS;
      val_err <= 1'b0;
      req_invalid <= 1'b0;
    end
    else
    begin
      cmpl_valid <= dn_apply && dn_last; // RULE_05 RULE_13
      val_err <= (done_valid && !dn_hit) || (reply_fire && !(rep_ok && rep_room)); // RULE_22
      req_invalid <= req_fire && !is_fast && !req_mapped;
      if (dn_apply && dn_last)
      begin
        cmpl_write <= done_write;
        cmpl_tag <= ent_tag[dn_idx]; // RULE_07 RULE_15
        cmpl_uid <= dn_uid_hit ? dn_uid : '0;
        cmpl_code <= dn_fail ? `TTT_RC_FAILED : `TTT_RC_SUCCESS; // RULE_08 RULE_21
      end
    end
  end

  // Read data launch: validated replies and fast reads
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      send_valid <= 1'b0;
      send_fast <= 1'b0;
      send_tag <= '0;
      send_channel <= '0;
      send_offset <= '0;
      send_count <= '0;
    end
    else
    begin
      send_valid <= rep_accept || fast_fire; // RULE_04 RULE_09
      if (rep_accept)
      begin
        send_fast <= 1'b0;
        send_tag <= reply_tag;
        send_channel <= reply_channel;
        send_offset <= reply_offset;
        send_count <= reply_count;
      end
      else if (fast_fire)
      begin
        send_fast <= 1'b1;
        send_tag <= req_tag;
        send_channel <= req_channel;
        send_offset <= '0;
        send_count <= req_count;
      end
    end
  end

  // Fast read tracking
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      fast_busy <= 1'b0;
      fast_cmpl_valid <= 1'b0;
      fast_cmpl_tag <= '0;
    end
    else
    begin
      fast_cmpl_valid <= fast_busy && fast_last; // RULE_10
      if (fast_fire)
      begin
        fast_busy <= 1'b1;
        fast_cmpl_tag <= req_tag;
      end
      else if (fast_last)
        fast_busy <= 1'b0;
    end
  end

  // Outgoing control messages
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctl_valid <= 1'b0;
      ctl_type <= MSG_DATA_READY;
      ctl_tag <= '0;
      ctl_rpid <= '0;
      ctl_channel <= '0;
      ctl_xfer_id <= '0;
      ctl_count <= '0;
      ctl_code <= `TTT_RC_SUCCESS;
    end
    else if (q_load)
    begin
      ctl_valid <= 1'b1;
      ctl_type <= MSG_RESPONSE;
      ctl_rpid <= q_rpid;
      ctl_code <= q_code; // RULE_17
    end
    else if (new_entry)
    begin
      ctl_valid <= 1'b1;
      ctl_type <= (req_kind == KIND_WRITE) ? MSG_DATA_REQUEST : MSG_DATA_READY; // RULE_01 RULE_11
      ctl_tag <= req_tag;
      ctl_rpid <= req_rpid;
      ctl_channel <= req_channel;
      ctl_xfer_id <= req_xfer_id;
      ctl_count <= req_count;
      ctl_code <= `TTT_RC_SUCCESS;
    end
    else if (ctl_ready)
      ctl_valid <= 1'b0;
  end

  // Quiesce sequencing
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      q_state <= Q_IDLE;
      q_rpid <= '0;
      q_code <= `TTT_RC_SUCCESS;
    end
    else
    begin
      case (q_state)
        Q_IDLE:
          if (quiesce_valid)
          begin
            q_rpid <= quiesce_rpid;
            q_state <= Q_ABORT;
          end
        Q_ABORT:
          if (abort_ack)
          begin
            q_code <= abort_code;
            q_state <= Q_RESP;
          end
        Q_RESP:
          if (!ctl_valid)
            q_state <= Q_IDLE;
        default:
          q_state <= Q_IDLE;
      endcase
    end
  end

  // Node identity query
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      uidq_done <= 1'b0;
      uidq_hit <= 1'b0;
      uidq_uid <= '0;
    end
    else
    begin
      uidq_done <= uidq_valid;
      if (uidq_valid)
      begin
        uidq_hit <= q_uid_hit; // RULE_19
        uidq_uid <= q_uid;
      end
    end
  end

  ready_msg_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
    new_entry && req_kind == KIND_READ |=> ctl_valid && ctl_type == MSG_DATA_READY)
    else $error("read request sent no DATA READY");
  request_msg_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_11
    new_entry && req_kind == KIND_WRITE |=> ctl_valid && ctl_type == MSG_DATA_REQUEST)
    else $error("write request sent no DATA REQUEST");
  reply_send_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
    rep_accept |=> send_valid && !send_fast && send_count == $past(reply_count) &&
    send_channel == $past(reply_channel))
    else $error("validated reply did not launch data");
  reply_err_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_22
    reply_fire && !rep_hit |=> val_err && !send_valid)
    else $error("unmatched reply not flagged");
  chan_keep_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
    dn_apply && !dn_last |=> !cmpl_valid && ent_valid[$past(dn_idx)])
    else $error("entry lost on non-final channel");
  entry_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
    dn_apply && dn_last |=> cmpl_valid && !ent_valid[$past(dn_idx)])
    else $error("final channel did not complete and clear");
  fail_code_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
    dn_apply && dn_last && done_failed |=> cmpl_valid && cmpl_code == `TTT_RC_FAILED)
    else $error("failed transfer not reported as failed");
  fast_done_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_10
    fast_busy && fast_last |=> fast_cmpl_valid && !fast_busy)
    else $error("fast read completion missing");
  abort_req_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_16
    quiesce_valid && quiesce_ready |=> abort_req)
    else $error("quiesce did not request abort");
  resp_code_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_17
    q_load |=> ctl_valid && ctl_type == MSG_RESPONSE && ctl_code == $past(q_code))
    else $error("response code does not follow abort result");
endmodule : ttt_tracker

// ---- rtl/ttt_defines.svh ----
// Widths, codes and byte positions of the target transfer tracker
`ifndef TTT_DEFINES_SVH
`define TTT_DEFINES_SVH
`define TTT_TAG_W 16
`define TTT_RPID_W 32
`define TTT_UID_W 64
`define TTT_CH_W 16
`define TTT_XID_W 8
`define TTT_CNT_W 32
`define TTT_CODE_W 8
`define TTT_RC_SUCCESS 8'h00
`define TTT_RC_FAILED 8'hFE
`define TTT_RC_INVALID 8'hFF
`define TTT_SUBST_FIRST 8'h04
`define TTT_SUBST_LAST 8'h07
`endif

// ---- rtl/ttt_pkg.sv ----
// Types of the target transfer tracker
package ttt_pkg;
  typedef enum logic [1:0] {
    KIND_READ = 2'b00,
    KIND_FAST = 2'b01,
    KIND_WRITE = 2'b10
  } ttt_kind_t;
  typedef enum logic [1:0] {
    MSG_DATA_READY = 2'b00,
    MSG_DATA_REQUEST = 2'b01,
    MSG_RESPONSE = 2'b10
  } ttt_msg_t;
  typedef enum logic [1:0] {
    Q_IDLE = 2'b00,
    Q_ABORT = 2'b01,
    Q_RESP = 2'b10
  } ttt_qstate_t;
endpackage : ttt_pkg

// ---- rtl/ttt_path_map.sv ----
// Return path identifier to node identity map with two-way lookups
`timescale 1ns/10ps
`include "ttt_defines.svh"
module ttt_path_map
  import ttt_pkg::*;
#(
  parameter int SLOTS = 8
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [$clog2(SLOTS)-1:0] wr_slot,
  input wire logic [`TTT_RPID_W-1:0] wr_rpid,
  input wire logic [`TTT_UID_W-1:0] wr_uid,
  input wire logic [`TTT_RPID_W-1:0] a_rpid,
  output logic [`TTT_UID_W-1:0] a_uid,
  output logic a_hit,
  input wire logic [`TTT_RPID_W-1:0] b_rpid,
  output logic [`TTT_UID_W-1:0] b_uid,
  output logic b_hit,
  input wire logic [`TTT_UID_W-1:0] c_uid,
  output logic [`TTT_RPID_W-1:0] c_rpid,
  output logic c_hit,
  input wire logic [`TTT_UID_W-1:0] d_uid,
  output logic [`TTT_RPID_W-1:0] d_rpid
);
  logic [SLOTS-1:0] slot_valid;
  logic [`TTT_RPID_W-1:0] slot_rpid [SLOTS];
  logic [`TTT_UID_W-1:0] slot_uid [SLOTS];

  // Lowest matching slot wins; top bit is the hit flag
  function automatic logic [`TTT_UID_W:0] uid_of(input logic [`TTT_RPID_W-1:0] r);
    logic [`TTT_UID_W:0] res;
    res = '0;
    for (int i = SLOTS - 1; i >= 0; i--)
      if (slot_valid[i] && slot_rpid[i] == r) res = {1'b1, slot_uid[i]};
    return res;
  endfunction : uid_of

  function automatic logic [`TTT_RPID_W:0] rpid_of(input logic [`TTT_UID_W-1:0] u);
    logic [`TTT_RPID_W:0] res;
    res = '0;
    for (int i = SLOTS - 1; i >= 0; i--)
      if (slot_valid[i] && slot_uid[i] == u) res = {1'b1, slot_rpid[i]};
    return res;
  endfunction : rpid_of

  logic d_hit_unused;
  assign {a_hit, a_uid} = uid_of(a_rpid); // RULE_19
  assign {b_hit, b_uid} = uid_of(b_rpid); // RULE_19
  assign {c_hit, c_rpid} = rpid_of(c_uid);
  assign {d_hit_unused, d_rpid} = rpid_of(d_uid); // RULE_18

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      slot_valid <= '0;
    else if (wr_en)
    begin
      slot_valid[wr_slot] <= 1'b1;
      slot_rpid[wr_slot] <= wr_rpid;
      slot_uid[wr_slot] <= wr_uid;
    end
  end
endmodule : ttt_path_map

// ---- rtl/ttt_path_subst.sv ----
// Outgoing message byte stream with return path substitution in bytes 4 to 7
`timescale 1ns/10ps
`include "ttt_defines.svh"
module ttt_path_subst
  import ttt_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic in_first,
  input wire logic [7:0] in_byte,
  input wire logic path_substitute_flag,
  input wire logic [`TTT_RPID_W-1:0] sub_rpid,
  output logic out_valid,
  output logic [7:0] out_byte
);
  logic [7:0] byte_idx;
  wire [7:0] cur_idx = in_first ? 8'h00 : byte_idx;
  wire in_window = path_substitute_flag && cur_idx >= `TTT_SUBST_FIRST &&
                   cur_idx <= `TTT_SUBST_LAST;
  wire [1:0] lane = 2'(cur_idx - `TTT_SUBST_FIRST);
  wire [`TTT_RPID_W-1:0] shifted = sub_rpid << {lane, 3'h0};
  wire [7:0] next_byte = in_window ? shifted[31:24] : in_byte; // RULE_18

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      out_byte <= 8'h00;
      byte_idx <= 8'h00;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
      begin
        out_byte <= next_byte;
        byte_idx <= (cur_idx == 8'hFF) ? cur_idx : cur_idx + 8'h01;
      end
    end
  end

  subst_first_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_18
    in_valid && path_substitute_flag && cur_idx == `TTT_SUBST_FIRST
    |=> out_valid && out_byte == 8'($past(sub_rpid) >> 24))
    else $error("byte 4 not replaced by return path");
endmodule : ttt_path_subst

// ---- bench/ttt_initiator_model.sv ----
// Initiator message side: takes control messages, answers DATA READY
`timescale 1ns/10ps
`include "ttt_defines.svh"
module ttt_initiator_model
  import ttt_pkg::*;
#(
  parameter logic [`TTT_CH_W-1:0] CH = 16'h0005
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] slow,
  input wire logic ctl_valid,
  input wire ttt_msg_t ctl_type,
  input wire logic [`TTT_TAG_W-1:0] ctl_tag,
  input wire logic [`TTT_RPID_W-1:0] ctl_rpid,
  input wire logic [`TTT_XID_W-1:0] ctl_xfer_id,
  input wire logic [`TTT_CNT_W-1:0] ctl_count,
  output logic ctl_ready,
  input wire logic reply_ready,
  output logic reply_valid,
  output logic [`TTT_TAG_W-1:0] reply_tag,
  output logic [`TTT_RPID_W-1:0] reply_rpid,
  output logic [`TTT_XID_W-1:0] reply_xfer_id,
  output logic [`TTT_CH_W-1:0] reply_channel,
  output logic [`TTT_CNT_W-1:0] reply_offset,
  output logic [`TTT_CNT_W-1:0] reply_count
);
  logic [3:0] wait_n;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctl_ready <= 1'b0;
      reply_valid <= 1'b0;
      wait_n <= 4'h0;
      {reply_tag, reply_rpid, reply_xfer_id, reply_channel, reply_offset, reply_count} <= '0;
    end
    else
    begin
      ctl_ready <= 1'b0;
      if (reply_valid && reply_ready)
      begin
        // Released reply lines show no stale value
        reply_valid <= 1'b0;
        {reply_tag, reply_rpid, reply_xfer_id, reply_channel, reply_offset, reply_count} <=
          ~{reply_tag, reply_rpid, reply_xfer_id, reply_channel, reply_offset, reply_count};
      end
      if (ctl_valid && !ctl_ready && wait_n < slow)
        wait_n <= wait_n + 4'h1;
      else if (ctl_valid && !ctl_ready)
      begin
        ctl_ready <= 1'b1;
        wait_n <= 4'h0;
        if (ctl_type == MSG_DATA_READY)
        begin
          reply_valid <= 1'b1;
          reply_tag <= ctl_tag;
          reply_rpid <= ctl_rpid;
          reply_xfer_id <= ctl_xfer_id;
          reply_channel <= CH;
          reply_offset <= 32'h00000000;
          reply_count <= ctl_count;
        end
      end
    end
  end
endmodule : ttt_initiator_model

// ---- bench/tb_ttt_tracker.sv ----
// Self-checking bench of the target transfer tracker
`timescale 1ns/10ps
`include "ttt_defines.svh"
module tb_ttt_tracker
  import ttt_pkg::*;
;
  localparam logic [31:0] R = 32'hA1B2C3D4;
  localparam logic [31:0] Q = 32'h55AA7733;
  localparam logic [63:0] U = 64'h0123456789ABCDEF;
  localparam logic [15:0] CH = 16'h0005;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid, req_ready, req_invalid, ctl_valid, ctl_ready, reply_valid, reply_ready;
  logic send_valid, send_fast, done_valid, done_write, done_failed, fast_last, fast_cmpl_valid;
  logic cmpl_valid, cmpl_write, val_err, quiesce_valid, quiesce_ready, abort_req, abort_ack;
  logic uidq_valid, uidq_done, uidq_hit, map_wr, tx_valid, tx_first, path_substitute_flag;
  logic txo_valid;
  ttt_kind_t req_kind;
  ttt_msg_t ctl_type;
  logic [15:0] req_tag, ctl_tag, reply_tag, send_tag, fast_cmpl_tag, cmpl_tag;
  logic [15:0] req_channel, ctl_channel, reply_channel, send_channel, done_channel;
  logic [63:0] req_uid, cmpl_uid, uidq_uid, map_uid, tx_uid;
  logic [31:0] ctl_rpid, reply_rpid, quiesce_rpid, uidq_rpid, map_rpid;
  logic [31:0] req_count, ctl_count, reply_offset, reply_count, send_offset, send_count;
  logic [7:0] req_xfer_id, ctl_xfer_id, reply_xfer_id, ctl_code, abort_code, cmpl_code;
  logic [7:0] tx_byte, txo_byte;
  logic [2:0] map_slot;
  logic [3:0] slow;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  ttt_tracker #(.NUM_ENT(4), .MAX_CH(4), .MAP_SLOTS(8)) i_ttt_tracker (.*);
  ttt_initiator_model #(.CH(CH)) i_ttt_initiator_model (.*);
  always #5 clock = ~clock;
  task step;
    @(posedge clock);
    #1;
  endtask : step
  task check(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task final_report;
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  task wait_on(input bit sel);
    for (int i = 0; i < 40 && (sel ? send_valid : ctl_valid) !== 1'b1; i++)
      step();
  endtask : wait_on
  task request(input ttt_kind_t k, input logic [15:0] tag, input logic [15:0] ch,
               input logic [63:0] uid);
    {req_valid, req_tag, req_uid, req_channel} = {1'b1, tag, uid, ch};
    {req_xfer_id, req_count} = {8'h21, 32'h00000040};
    req_kind = k;
    #1;
    while (req_ready !== 1'b1)
      step();
    step();
    req_valid = 1'b0;
  endtask : request
  task done_pulse(input logic wr, input logic [15:0] ch, input logic bad);
    {done_valid, done_write, done_channel, done_failed} = {1'b1, wr, ch, bad};
    step();
    done_valid = 1'b0;
  endtask : done_pulse
  task t_map;
    {map_wr, map_slot, map_rpid, map_uid} = {1'b1, 3'h0, R, U};
    step();
    {map_wr, uidq_valid, uidq_rpid} = {1'b0, 1'b1, R};
    step();
    uidq_valid = 1'b0;
    check({uidq_done, uidq_hit, uidq_uid}, {2'h3, U});
  endtask : t_map
  task t_read;
    request(KIND_READ, 16'h1234, 16'h0000, U);
    check({ctl_valid, ctl_type, ctl_xfer_id}, {1'b1, MSG_DATA_READY, 8'h21});
    check({ctl_tag, ctl_rpid, ctl_count}, {16'h1234, R, 32'h00000040});
    wait_on(1'b1);
    check({send_fast, send_tag, send_channel}, {1'b0, 16'h1234, CH});
    check({send_offset, send_count}, {32'h00000000, 32'h00000040});
    done_pulse(1'b0, CH, 1'b0);
    check({cmpl_valid, cmpl_write, cmpl_tag}, {2'h2, 16'h1234});
    check(cmpl_uid, U);
    check(cmpl_code, `TTT_RC_SUCCESS);
    step();
    done_pulse(1'b0, CH, 1'b0);
    check({val_err, cmpl_valid}, 2'h2);
  endtask : t_read
  task t_write;
    request(KIND_WRITE, 16'h0BEE, 16'h0009, U);
    check({ctl_type, ctl_channel}, {MSG_DATA_REQUEST, 16'h0009});
    repeat (4) step();
    done_pulse(1'b1, 16'h0009, 1'b1);
    check({cmpl_valid, cmpl_write, cmpl_tag}, {2'h3, 16'h0BEE});
    check(cmpl_code, `TTT_RC_FAILED);
    request(KIND_WRITE, 16'h0BEF, 16'h000A, ~U);
    check({req_invalid, ctl_valid}, 2'h2);
  endtask : t_write
  task t_fast;
    request(KIND_FAST, 16'h0777, 16'h0003, U);
    check({send_valid, send_fast, send_channel, ctl_valid}, {2'h3, 16'h0003, 1'b0});
    step();
    fast_last = 1'b1;
    step();
    fast_last = 1'b0;
    check({fast_cmpl_valid, fast_cmpl_tag}, {1'b1, 16'h0777});
  endtask : t_fast
  task t_quiesce;
    {slow, quiesce_valid, quiesce_rpid} = {4'h3, 1'b1, Q};
    step();
    quiesce_valid = 1'b0;
    check(abort_req, 1'b1);
    {abort_ack, abort_code} = {1'b1, `TTT_RC_INVALID};
    step();
    abort_ack = 1'b0;
    wait_on(1'b0);
    check({ctl_type, ctl_rpid, ctl_code}, {MSG_RESPONSE, Q, `TTT_RC_INVALID});
  endtask : t_quiesce
  task t_subst;
    logic [7:0] exp;
    {path_substitute_flag, tx_uid, tx_valid} = {1'b1, U, 1'b1};
    for (int i = 0; i < 8; i++)
    begin
      {tx_first, tx_byte} = {i == 0, 8'(i) | 8'h30};
      exp = (i > 3) ? 8'(R >> (8 * (7 - i))) : 8'(i) | 8'h30;
      step();
      check({txo_valid, txo_byte}, {1'b1, exp});
    end
    tx_valid = 1'b0;
  endtask : t_subst
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    {req_valid, req_tag, req_uid, req_channel, req_xfer_id, req_count, slow} = '0;
    {done_valid, done_write, done_channel, done_failed, fast_last, abort_ack, abort_code} = '0;
    {quiesce_valid, quiesce_rpid, uidq_valid, uidq_rpid, map_wr, map_slot, map_rpid} = '0;
    {map_uid, tx_valid, tx_first, tx_byte, path_substitute_flag, tx_uid} = '0;
    req_kind = KIND_READ;
    repeat (6) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_map();
    t_read();
    t_write();
    t_fast();
    t_quiesce();
    t_subst();
    final_report();
  end
endmodule : tb_ttt_tracker
